// ---- tssc_touch_sense_scan_control.sv ----
/*
  Touch sense scan controller: APB register file, trigger handling,
  scan sequencing, result accumulation and noise detection duration.
  Assumes the reference and electrode oscillators arrive as free
  running square waves much slower than clk_sys_in, and that the
  hardware trigger is an asynchronous level whose rising edge counts.
*/
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module tssc_touch_sense_scan_control
  import tssc_pkg::*;
#(
  parameter int NUM_PINS = 16,
  parameter int COUNT_W  = 16
) (
  input  wire logic                clk_sys_in,
  input  wire logic                srst_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [7:0]          paddr_in,
  input  wire logic [31:0]         pwdata_in,
  input  wire logic [3:0]          pstrb_in,
  output logic                     pready_out,
  output logic [31:0]              prdata_out,
  output logic                     pslverr_out,
  input  wire logic                ref_osc_in,
  input  wire logic                elec_osc_in,
  input  wire logic                hw_trigger_in,
  input  wire logic                stop3_in,
  output logic [NUM_PINS-1:0]      electrode_pin_enable_out,
  output logic [TSSC_CHAN_W-1:0]   channel_select_out,
  output logic [TSSC_DVOLT_W-1:0]  dvolt_out,
  output logic [TSSC_CUR_W-1:0]    elec_osc_current_out,
  output logic [TSSC_CUR_W-1:0]    ref_osc_current_out,
  output logic [TSSC_CUR_W-1:0]    series_resistance_out,
  output logic                     noise_mode_out,
  output logic                     scan_active_out,
  output logic                     irq_out,
  output logic                     wake_out
);
  // ==========================================================
  // Register state
  logic [7:0]          ctrl_q;
  logic [7:0]          cfg_q;
  logic [7:0]          cur_q;
  logic [7:0]          chan_q;
  logic [15:0]         pen_q;
  logic                end_of_scan_flag_q;
  logic [31:0]         prdata_q;
  logic [31:0]         rd_data;
  logic                mapped;
  logic                wr_access;
  logic                wr_ctrl;
  tssc_state_type      state_q;
  logic [COUNT_W-1:0]  count_q;
  logic [5:0]          scan_num_q;
  logic [7:0]          div_q;
  logic [12:0]         dur_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_access = psel_in & penable_in & pwrite_in & mapped;
  assign wr_ctrl   = wr_access & hit(paddr_in, TSSC_OFF_CTRL) & pstrb_in[0];

  // ==========================================================
  // APB decode and read mux
  always_comb begin
    mapped  = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr_in)
      TSSC_OFF_CTRL: begin
        rd_data[7:0] = ctrl_q;
        rd_data[TSSC_CTRL_SWTR_BIT] = 1'b0;
        rd_data[TSSC_CTRL_SCAN_BIT] = (state_q == TSSC_SCAN);
        rd_data[TSSC_CTRL_END_OF_SCAN_FLAG_BIT] = end_of_scan_flag_q;
      end
      TSSC_OFF_CFG:   rd_data[7:0] = cfg_q;
      TSSC_OFF_CUR:   rd_data[7:0] = cur_q;
      TSSC_OFF_CHAN:  rd_data[7:0] = chan_q;
      TSSC_OFF_PEN:   rd_data[15:0] = pen_q;
      TSSC_OFF_COUNT: rd_data[15:0] = 16'(count_q);
      default:        mapped = 1'b0;
    endcase
  end

  // Read data is caught in the setup cycle so the output is a flop
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_in & ~penable_in) begin
      prdata_q <= rd_data;
    end
  end

  assign pready_out  = psel_in & penable_in;
  assign pslverr_out = psel_in & penable_in & ~mapped;
  assign prdata_out  = prdata_q;

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctrl_q <= TSSC_RST_CTRL;
      cfg_q  <= TSSC_RST_CFG;
      cur_q  <= TSSC_RST_CUR;
      chan_q <= TSSC_RST_CHAN;
      pen_q  <= TSSC_RST_PEN;
    end else if (wr_access) begin
      if (hit(paddr_in, TSSC_OFF_CTRL) & pstrb_in[0]) begin
        ctrl_q <= {2'h0, pwdata_in[5:4], 1'b0, pwdata_in[2:0]};
      end
      if (hit(paddr_in, TSSC_OFF_CFG) & pstrb_in[0]) begin
        cfg_q <= pwdata_in[7:0];
      end
      if (hit(paddr_in, TSSC_OFF_CUR) & pstrb_in[0]) begin
        cur_q <= pwdata_in[7:0];
      end
      if (hit(paddr_in, TSSC_OFF_CHAN) & pstrb_in[0]) begin
        chan_q <= pwdata_in[7:0];
      end
      if (hit(paddr_in, TSSC_OFF_PEN) & pstrb_in[0]) begin
        pen_q[7:0] <= pwdata_in[7:0];
      end
      if (hit(paddr_in, TSSC_OFF_PEN) & pstrb_in[1]) begin
        pen_q[15:8] <= pwdata_in[15:8];
      end
    end
  end

  // ==========================================================
  // Field views
  logic                    mod_en;
  logic                    lp_run_en;
  logic                    trig_sel;
  logic                    swap;
  logic                    int_en;
  logic [TSSC_SCAN_COUNT_W-1:0]  nscan;
  logic [TSSC_PS_W-1:0]    ps;
  logic [TSSC_CUR_W-1:0]   ref_sel;
  logic [TSSC_CUR_W-1:0]   ext_sel;
  logic                    noise_mode;
  logic                    active;
  logic [7:0]              div_max;
  logic [12:0]             term;

  assign mod_en     = ctrl_q[TSSC_CTRL_EN_BIT];
  assign lp_run_en  = ctrl_q[TSSC_CTRL_LPRE_BIT];
  assign trig_sel   = ctrl_q[TSSC_CTRL_TSEL_BIT];
  assign swap       = ctrl_q[TSSC_CTRL_SWAP_BIT];
  assign int_en     = ctrl_q[TSSC_CTRL_IE_BIT];
  assign nscan      = cfg_q[TSSC_SCAN_COUNT_LSB +: TSSC_SCAN_COUNT_W];
  assign ps         = cfg_q[TSSC_PS_LSB +: TSSC_PS_W];
  assign ref_sel    = cur_q[TSSC_REFI_LSB +: TSSC_CUR_W];
  assign ext_sel    = cur_q[TSSC_EXTI_LSB +: TSSC_CUR_W];
  assign noise_mode = (chan_q[TSSC_STUP_LSB+2 +: 2] == TSSC_NOISE_CODE);
  // Stop3 without low power run enable freezes the scan instead of aborting it, so it resumes later
  assign active     = mod_en & (~stop3_in | lp_run_en);
  assign div_max    = (8'h01 << ps) - 8'h01;
  assign term       = (13'(nscan) + 13'h0001) << ps;

  // ==========================================================
  // Oscillator and trigger synchronisers
  logic [2:0] ref_s_q;
  logic [2:0] elec_s_q;
  logic [2:0] trig_s_q;
  logic       ref_edge;
  logic       elec_edge;
  logic       hw_edge;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ref_s_q  <= 3'h0;
      elec_s_q <= 3'h0;
      trig_s_q <= 3'h0;
    end else begin
      ref_s_q  <= {ref_s_q[1:0], ref_osc_in};
      elec_s_q <= {elec_s_q[1:0], elec_osc_in};
      trig_s_q <= {trig_s_q[1:0], hw_trigger_in};
    end
  end

  assign ref_edge  = ref_s_q[1] & ~ref_s_q[2];
  assign elec_edge = elec_s_q[1] & ~elec_s_q[2];
  assign hw_edge   = trig_s_q[1] & ~trig_s_q[2];

  // ==========================================================
  // Scan sequencing
  logic start;
  logic seq_done;
  logic sw_trig;

  assign sw_trig = wr_ctrl & pwdata_in[TSSC_CTRL_SWTR_BIT];
  // Triggers while busy are dropped, not queued
  assign start = active & (state_q == TSSC_IDLE) &
                 (trig_sel ? hw_edge : sw_trig);
  assign seq_done = active & (state_q == TSSC_SCAN) & (noise_mode ?
                    (ref_edge & (dur_q == term - 13'h0001)) :
                    (elec_edge & (div_q == div_max) &
                     (scan_num_q == 6'(nscan))));

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_q <= TSSC_IDLE;
    end else begin
      case (state_q)
        TSSC_IDLE: if (start) state_q <= TSSC_SCAN;
        TSSC_SCAN: if (~mod_en | seq_done) state_q <= TSSC_IDLE;
        default:   state_q <= TSSC_IDLE;
      endcase
    end
  end

  // Prescaler, scan number and noise duration counters
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      div_q      <= 8'h00;
      scan_num_q <= 6'h00;
      dur_q      <= 13'h0000;
    end else if (start) begin
      div_q      <= 8'h00;
      scan_num_q <= 6'h00;
      dur_q      <= 13'h0000;
    end else if (active & (state_q == TSSC_SCAN)) begin
      if (noise_mode) begin
        if (ref_edge) dur_q <= dur_q + 13'h0001;
      end else if (elec_edge) begin
        if (div_q == div_max) begin
          div_q      <= 8'h00;
          scan_num_q <= scan_num_q + 6'h01;
        end else begin
          div_q <= div_q + 8'h01;
        end
      end
    end
  end

  // Result accumulator; wraps silently at the counter width
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      count_q <= '0;
    end else if (start) begin
      count_q <= '0;
    end else if (active & (state_q == TSSC_SCAN)) begin
      if (noise_mode ? elec_edge : ref_edge) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // End of scan flag: a completion in the clearing cycle wins
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      end_of_scan_flag_q <= 1'b0;
    end else if (seq_done) begin
      end_of_scan_flag_q <= 1'b1;
    end else if (wr_ctrl & pwdata_in[TSSC_CTRL_END_OF_SCAN_FLAG_BIT]) begin
      end_of_scan_flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // Analog side controls
  assign electrode_pin_enable_out = NUM_PINS'(pen_q);
  assign channel_select_out    = chan_q[TSSC_CHAN_LSB +: TSSC_CHAN_W];
  assign dvolt_out             = cur_q[TSSC_DVOLT_LSB +: TSSC_DVOLT_W];
  assign elec_osc_current_out  = swap ? ref_sel : ext_sel;
  assign ref_osc_current_out   = swap ? ext_sel : ref_sel;
  assign series_resistance_out = ext_sel;
  assign noise_mode_out        = noise_mode & mod_en;
  assign scan_active_out       = (state_q == TSSC_SCAN);
  assign irq_out               = end_of_scan_flag_q & int_en;
  assign wake_out              = end_of_scan_flag_q & int_en & stop3_in;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  sequence s_start;
    start ##1 (state_q == TSSC_SCAN);
  endsequence

  a_disable_idles: assert property (~mod_en |=> state_q == TSSC_IDLE)
    else $error("scan kept running while disabled");
  a_stop3_freeze: assert property ((stop3_in & ~lp_run_en) |=>
      $stable(count_q) || $past(start))
    else $error("counter moved in stop3 without low power enable");
  a_sw_trigger_start: assert property ((sw_trig & ~trig_sel & active &
      state_q == TSSC_IDLE) |-> s_start)
    else $error("software trigger did not start a scan");
  a_hw_wait: assert property ((trig_sel & ~hw_edge &
      state_q == TSSC_IDLE) |=> state_q == TSSC_IDLE)
    else $error("scan began without hardware trigger");
  a_start_clears: assert property (start |=>
      count_q == '0 && scan_num_q == 6'h00 && dur_q == 13'h0000)
    else $error("counters not cleared at scan start");
  a_done_flags: assert property (seq_done |=>
      end_of_scan_flag_q && state_q == TSSC_IDLE && !scan_active_out)
    else $error("completion did not raise end of scan");
  a_accumulate: assert property ((active & ~noise_mode & ref_edge &
      state_q == TSSC_SCAN & ~start) |=> count_q == $past(count_q) + 1'b1)
    else $error("reference edge not accumulated");
  a_noise_term: assert property ((noise_mode & active & ref_edge &
      state_q == TSSC_SCAN & dur_q == term - 13'h0001) |=> end_of_scan_flag_q)
    else $error("noise duration did not end the scan");
  a_irq_follows: assert property ((seq_done & int_en) |=> irq_out)
    else $error("interrupt missing after completion");
  a_swap_sources: assert property (swap |->
      elec_osc_current_out == ref_sel && ref_osc_current_out == ext_sel)
    else $error("current sources not swapped");
  a_scan_advance: assert property ((active & ~noise_mode & elec_edge &
      state_q == TSSC_SCAN & div_q == div_max & ~seq_done) |=>
      scan_num_q == $past(scan_num_q) + 6'h01)
    else $error("scan number did not advance");
  a_end_of_scan_flag_holds: assert property ((end_of_scan_flag_q & ~(wr_ctrl &
      pwdata_in[TSSC_CTRL_END_OF_SCAN_FLAG_BIT])) |=> end_of_scan_flag_q)
    else $error("end of scan flag dropped without a clear");
  a_end_of_scan_flag_clears: assert property ((wr_ctrl & ~seq_done &
      pwdata_in[TSSC_CTRL_END_OF_SCAN_FLAG_BIT]) |=> !end_of_scan_flag_q)
    else $error("end of scan flag survived its clear");
endmodule : tssc_touch_sense_scan_control

// ---- tssc_pkg.sv ----
/*
  Constants for the touch sense scan controller: APB register offsets,
  field positions, reset values and the scan state type.
  Assumes a 32-bit APB with byte addresses and one register per word.
*/
package tssc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] TSSC_OFF_CTRL  = 8'h00;
  localparam logic [7:0] TSSC_OFF_CFG   = 8'h04;
  localparam logic [7:0] TSSC_OFF_CUR   = 8'h08;
  localparam logic [7:0] TSSC_OFF_CHAN  = 8'h0c;
  localparam logic [7:0] TSSC_OFF_PEN   = 8'h10;
  localparam logic [7:0] TSSC_OFF_COUNT = 8'h14;
  // ==========================================================
  // Control register bits
  localparam int TSSC_CTRL_EN_BIT    = 0;
  localparam int TSSC_CTRL_LPRE_BIT  = 1;
  localparam int TSSC_CTRL_TSEL_BIT  = 2;
  localparam int TSSC_CTRL_SWTR_BIT  = 3;
  localparam int TSSC_CTRL_SWAP_BIT  = 4;
  localparam int TSSC_CTRL_IE_BIT    = 5;
  localparam int TSSC_CTRL_SCAN_BIT  = 6;
  localparam int TSSC_CTRL_END_OF_SCAN_FLAG_BIT  = 7;
  // ==========================================================
  // Field positions
  localparam int TSSC_SCAN_COUNT_LSB  = 0;
  localparam int TSSC_SCAN_COUNT_W    = 5;
  localparam int TSSC_PS_LSB    = 5;
  localparam int TSSC_PS_W      = 3;
  localparam int TSSC_REFI_LSB  = 0;
  localparam int TSSC_EXTI_LSB  = 3;
  localparam int TSSC_CUR_W     = 3;
  localparam int TSSC_DVOLT_LSB = 6;
  localparam int TSSC_DVOLT_W   = 2;
  localparam int TSSC_CHAN_LSB  = 0;
  localparam int TSSC_CHAN_W    = 4;
  localparam int TSSC_STUP_LSB  = 4;
  localparam int TSSC_STUP_W    = 4;
  localparam logic [1:0] TSSC_NOISE_CODE = 2'h3;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  TSSC_RST_CTRL = 8'h00;
  localparam logic [7:0]  TSSC_RST_CFG  = 8'h00;
  localparam logic [7:0]  TSSC_RST_CUR  = 8'h00;
  localparam logic [7:0]  TSSC_RST_CHAN = 8'h00;
  localparam logic [15:0] TSSC_RST_PEN  = 16'h0000;
  // ==========================================================
  // Scan state
  typedef enum logic [1:0] {
    TSSC_IDLE = 2'b01,
    TSSC_SCAN = 2'b10
  } tssc_state_type;
endpackage : tssc_pkg

// ---- tssc_osc_model.sv ----
/*
  Behavioural reference and electrode oscillators for the scan bench.
  Assumes clk_in is the 20 MHz system clock; periods are whole cycles.
*/
`timescale 1ns/1ps
module tssc_osc_model #(
  parameter int REF_HALF  = 4,
  parameter int ELEC_HALF = 16
) (
  input  wire logic        clk_in,
  input  wire logic [15:0] pin_en_in,
  input  wire logic [3:0]  chan_in,
  output logic             ref_osc_out,
  output logic             elec_osc_out
);
  int ref_cnt  = 0;
  int elec_cnt = 0;
  initial begin
    ref_osc_out  = 1'b0;
    elec_osc_out = 1'b0;
  end
  // ==========================================================
  // Reference runs free, four times the electrode rate
  always @(posedge clk_in) begin
    ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
    if (ref_cnt == REF_HALF - 1) begin
      ref_osc_out <= ~ref_osc_out;
    end
  end
  // ==========================================================
  // Electrode pad stands low unless its pin is enabled
  always @(posedge clk_in) begin
    if (pin_en_in[chan_in] !== 1'b1) begin
      elec_cnt     <= 0;
      elec_osc_out <= 1'b0;
    end else begin
      elec_cnt <= (elec_cnt == ELEC_HALF - 1) ? 0 : elec_cnt + 1;
      if (elec_cnt == ELEC_HALF - 1) begin
        elec_osc_out <= ~elec_osc_out;
      end
    end
  end
endmodule : tssc_osc_model

// ---- tb.sv ----
/*
  Self-checking bench for the touch sense scan controller.
  Assumes the package constants and the oscillator model file.
*/
`timescale 1ns/1ps
module tb;
  import tssc_pkg::*;
  typedef struct {logic [4:0] n; logic [2:0] ps; int exp;} tssc_row_type;
  logic clk_sys_in = 1'b0, srst_in = 1'b1, hw_trigger_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic stop3_in = 1'b0, pready_out, pslverr_out, err;
  logic [7:0] paddr_in = 8'h00;
  logic [3:0] pstrb_in = 4'hf;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd, held;
  logic ref_osc, elec_osc, noise_mode_out, scan_active_out, irq_out;
  logic wake_out;
  logic [15:0] pen;
  logic [3:0] chan;
  logic [1:0] dvolt;
  logic [2:0] ecur, rcur, rs, code;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  logic [7:0] offs [5] = '{TSSC_OFF_CTRL, TSSC_OFF_CFG, TSSC_OFF_CUR,
                           TSSC_OFF_CHAN, TSSC_OFF_PEN};
  tssc_row_type rows [5] = '{'{5'h00, 3'h0, 4}, '{5'h01, 3'h1, 16},
    '{5'h1f, 3'h0, 128}, '{5'h00, 3'h7, 512}, '{5'h03, 3'h2, 64}};

  always #25 clk_sys_in = ~clk_sys_in;

  tssc_touch_sense_scan_control tssc_touch_sense_scan_control_inst (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .pready_out(pready_out),
    .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .ref_osc_in(ref_osc), .elec_osc_in(elec_osc),
    .hw_trigger_in(hw_trigger_in), .stop3_in(stop3_in),
    .electrode_pin_enable_out(pen), .channel_select_out(chan),
    .dvolt_out(dvolt), .elec_osc_current_out(ecur),
    .ref_osc_current_out(rcur), .series_resistance_out(rs),
    .noise_mode_out(noise_mode_out), .scan_active_out(scan_active_out),
    .irq_out(irq_out), .wake_out(wake_out));

  tssc_osc_model tssc_osc_model_inst (.clk_in(clk_sys_in), .pin_en_in(pen),
    .chan_in(chan), .ref_osc_out(ref_osc), .elec_osc_out(elec_osc));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One idle edge after each transfer keeps psel from toggling twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    rd  = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : apb

  task automatic watch(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk_sys_in);
      if (scan_active_out === 1'b1) seen = 1'b1;
    end
    chk("scan_active", {31'h0, seen}, {31'h0, exp});
  endtask : watch

  // Polls the end flag rather than the busy flag, as software should
  task automatic wait_end_of_scan_flag;
    for (int i = 0; i < 3000; i++) begin
      apb(1'b0, TSSC_OFF_CTRL, 32'h0);
      if (rd[TSSC_CTRL_END_OF_SCAN_FLAG_BIT] === 1'b1) break;
    end
    chk("end_of_scan_flag", rd & 32'h80, 32'h80);
  endtask : wait_end_of_scan_flag

  task automatic chk_count(input int lo, input int hi);
    apb(1'b0, TSSC_OFF_COUNT, 32'h0);
    chk("count_in_range", (int'(rd[15:0]) >= lo &&
        int'(rd[15:0]) <= hi) ? 32'h1 : 32'h0, 32'h1);
  endtask : chk_count

  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Hang guard; the longest row takes about 4,100 cycles
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      chk("reset_value", rd, 32'h0);
    end
    apb(1'b1, 8'h3c, 32'h000000ff);
    chk("unmapped_error", {31'h0, err}, 32'h1);
    apb(1'b1, TSSC_OFF_PEN, 32'h00000020);
    apb(1'b1, TSSC_OFF_CHAN, 32'h00000005);
    chk("pin_enable", {16'h0, pen}, 32'h00000020);
    chk("channel", {28'h0, chan}, 32'h00000005);
    // A trigger is only taken once the enable already stands
    apb(1'b1, TSSC_OFF_CTRL, 32'h00000001);
    // Rows: the count restarts at each trigger, so no carry-over
    foreach (rows[i]) begin
      apb(1'b1, TSSC_OFF_CFG, {24'h0, rows[i].ps, rows[i].n});
      apb(1'b1, TSSC_OFF_CTRL, 32'h00000009);
      apb(1'b0, TSSC_OFF_CTRL, 32'h0);
      chk("scan_in_progress", rd & 32'h40, 32'h40);
      wait_end_of_scan_flag();
      chk_count(rows[i].exp - 5, rows[i].exp + 1);
      apb(1'b1, TSSC_OFF_CTRL, 32'h00000081);
      apb(1'b0, TSSC_OFF_CTRL, 32'h0);
      chk("end_of_scan_flag_cleared", rd & 32'h80, 32'h0);
    end
    apb(1'b1, TSSC_OFF_CTRL, 32'h00000008);
    watch(1'b0);
    stop3_in <= 1'b1;
    apb(1'b1, TSSC_OFF_CTRL, 32'h00000029);
    watch(1'b0);
    apb(1'b1, TSSC_OFF_CTRL, 32'h00000023);
    apb(1'b1, TSSC_OFF_CTRL, 32'h0000002b);
    watch(1'b1);
    wait_end_of_scan_flag();
    chk("irq", {31'h0, irq_out}, 32'h1);
    chk("wake", {31'h0, wake_out}, 32'h1);
    apb(1'b1, TSSC_OFF_CTRL, 32'h000000a3);
    chk("irq_cleared", {31'h0, irq_out}, 32'h0);
    stop3_in <= 1'b0;
    // Hardware mode must stand before the software strobe is ignored
    apb(1'b1, TSSC_OFF_CTRL, 32'h00000005);
    apb(1'b1, TSSC_OFF_CTRL, 32'h0000000d);
    watch(1'b0);
    hw_trigger_in <= 1'b1;
    watch(1'b1);
    hw_trigger_in <= 1'b0;
    // Stop3 without low power enable freezes the running scan
    stop3_in <= 1'b1;
    apb(1'b0, TSSC_OFF_COUNT, 32'h0);
    held = rd;
    watch(1'b1);
    apb(1'b0, TSSC_OFF_COUNT, 32'h0);
    chk("frozen_count", rd, held);
    stop3_in <= 1'b0;
    wait_end_of_scan_flag();
    apb(1'b1, TSSC_OFF_CTRL, 32'h00000081);
    for (int k = 0; k < 5; k++) begin
      code = 3'(k + 3);
      apb(1'b1, TSSC_OFF_CUR, {24'h0, 2'(3 - k % 4), code, 3'h1});
      chk("series_res", {29'h0, rs}, {29'h0, code});
      chk("dvolt", {30'h0, dvolt}, 32'(3 - k % 4));
      chk("elec_cur", {29'h0, ecur}, {29'h0, code});
      chk("ref_cur", {29'h0, rcur}, 32'h1);
    end
    apb(1'b1, TSSC_OFF_CTRL, 32'h00000011);
    chk("swap_elec", {29'h0, ecur}, 32'h1);
    chk("swap_ref", {29'h0, rcur}, 32'h7);
    apb(1'b1, TSSC_OFF_CHAN, 32'h000000c5);
    chk("noise_mode", {31'h0, noise_mode_out}, 32'h1);
    apb(1'b1, TSSC_OFF_CUR, 32'h000000d9);
    apb(1'b1, TSSC_OFF_CFG, 32'h00000067);
    apb(1'b1, TSSC_OFF_CTRL, 32'h00000009);
    wait_end_of_scan_flag();
    chk_count(14, 17);
    apb(1'b1, TSSC_OFF_CTRL, 32'h00000081);
    apb(1'b1, TSSC_OFF_CHAN, 32'h00000005);
    chk("normal_mode", {31'h0, noise_mode_out}, 32'h0);
    tally_and_finish();
  end
endmodule : tb
